/* fsp_regs.svh */
// Purpose: register indices, field positions and codes of the flash
//          self-program controller
// Assumes: included by its bare name
// Notes:   register indices select on the core's register port
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
// register indices on the core's register port
`define FSP_REG_CTRL 3'h0
`define FSP_REG_KEY 3'h1
`define FSP_REG_ADRL 3'h2
`define FSP_REG_ADRU 3'h3
`define FSP_REG_SRCL 3'h4
`define FSP_REG_SRCH 3'h5
`define FSP_REG_PAGE 3'h6
// control register field positions
`define FSP_CTRL_START 15
`define FSP_CTRL_ENABLE 14
`define FSP_CTRL_ERR 13
`define FSP_CTRL_FMT 9
// operation select codes
`define FSP_OP_DWORD 4'h1
`define FSP_OP_ROW 4'h2
`define FSP_OP_PAGE 4'h3
`define FSP_OP_BULK 4'he
// unlock key values
`define FSP_KEY_FIRST 16'h0055
`define FSP_KEY_SECOND 16'h00aa
// flash geometry in program address units, and double-word pairs per row
`define FSP_ROW_UNITS 24'h000100
`define FSP_PAGE_UNITS 24'h000800
`define FSP_DWORD_UNITS 24'h000004
`define FSP_ROW_PAIRS 7'h40
// control value after reset
`define FSP_CTRL_RESET 16'h0000
`endif

/* fsp_pkg.sv */
// Purpose: shared types of the flash self-program controller
// Assumes: nothing
// Notes:   constants live in fsp_regs.svh
package fsp_pkg;
  // request kinds on the core link
  typedef enum logic [1:0] {REQ_TBL_RD, REQ_TBL_WR, REQ_REG_WR, REQ_REG_RD}
    fsp_req_t;
  // commands to the flash array
  typedef enum logic [2:0] {FL_READ, FL_PROG, FL_ERASE_PAGE, FL_ERASE_ALL}
    fsp_fcmd_t;
  // user commands of the core end
  typedef enum logic [2:0] {UC_TBL_RD, UC_TBL_WR, UC_REG_WR, UC_REG_RD,
    UC_START} fsp_ucmd_t;
endpackage

/* fsp_if.sv */
// Purpose: link between processor core and flash self-program controller
// Assumes: one clock shared by both ends
// Notes:   one request outstanding at a time
`timescale 1ns/1ns
`default_nettype none
interface fsp_if;
  logic                req;       // request held until taken
  fsp_pkg::fsp_req_t   kind;      // request kind
  logic                high;      // table access to bits 23..16
  logic                byte_mode; // byte access, addr[0] selects byte
  logic [2:0]          sel;       // register index
  logic [15:0]         addr;      // effective address
  logic [15:0]         wdata;     // write data
  logic                stall;     // controller busy, core must wait
  logic                ack;       // one-cycle answer pulse
  logic [15:0]         rdata;     // read data, valid with ack
  logic                done_irq;  // one-cycle pulse on good completion
  modport dev (input req, kind, high, byte_mode, sel, addr, wdata,
               output stall, ack, rdata, done_irq);
  modport core (output req, kind, high, byte_mode, sel, addr, wdata,
                input stall, ack, rdata, done_irq);
endinterface
`default_nettype wire

/* fsp_ctrl.sv */
// Purpose: flash self-program controller, device end of the core link
// Assumes: flash array answers each request with one fl_done pulse
// Notes:   row data comes from ram through a request/ack read port
`timescale 1ns/1ns
`default_nettype none
`include "fsp_regs.svh"
// How it works
// - word low read returns bits 15..0
// - byte low read picks byte by select
// - word high read: bits 23..16, upper zero
// - byte high read: upper byte or zero
// - table address is page byte plus ea
// - low reaches 15..0, high 23..16, both modes
// - rows 128 instructions, pages 1024 instructions
// - erase and row blocks edge aligned
// - row 256 units, page 2048 units
// - row fetch from ram, addresses advance
// - format bit picks compressed ram layout
// - core loads two latches before double-word
// - completion pulse on good finish
// - start bit starts, clears when done
// - start needs 0x55 then 0xaa keys
// - core stalled while operation runs
// - core polls start bit until zero
// - two idle instructions after start
// - core erases page before writing
// - operation select codes, others reserved
// - enable bit gates every operation
// - improper start sets error flag
// - upper and lower target registers concatenate
module fsp_ctrl (
  // system
  input  wire logic               clk,
  input  wire logic               reset,
  // core link
  fsp_if.dev                      bus,
  // flash array
  output logic                    fl_req,
  output fsp_pkg::fsp_fcmd_t      fl_cmd,
  output logic [23:0]             fl_addr,
  output logic [23:0]             fl_wdata,
  input  wire logic [23:0]        fl_rdata,
  input  wire logic               fl_done,
  // row data ram
  output logic                    ram_req,
  output logic [23:0]             ram_addr,
  input  wire logic [15:0]        ram_rdata,
  input  wire logic               ram_ack
);
  typedef enum logic [2:0] {ST_IDLE, ST_TRD, ST_ERASE, ST_FETCH, ST_PROG}
    fsp_state_t;
  typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_OPEN} fsp_key_t;

  fsp_state_t  state, next_state;       // sequencer state
  fsp_key_t    key, next_key;           // unlock progress
  logic [7:0]  page, next_page;         // table page register
  logic        start, next_start;       // start bit
  logic        enable, next_enable;     // program enable bit
  logic        err, next_err;           // sequence error flag
  logic        fmt, next_fmt;           // row data format bit
  logic [3:0]  op, next_op;             // operation select field
  logic [23:0] adr, next_adr;           // flash target address
  logic [23:0] src, next_src;           // row source ram address
  logic [23:0] lat0, next_lat0;         // first write latch
  logic [23:0] lat1, next_lat1;         // second write latch
  logic        slot, next_slot;         // latch being programmed
  logic [1:0]  wcnt, next_wcnt;         // ram word within a pair
  logic [6:0]  pairs, next_pairs;       // pairs left in the row
  logic        rd_high, next_rd_high;   // captured read shape
  logic        rd_byte, next_rd_byte;
  logic        rd_sel, next_rd_sel;
  logic        ack, next_ack;
  logic [15:0] rdata, next_rdata;
  logic        done, next_done;
  logic        next_fl_req, next_ram_req;
  fsp_pkg::fsp_fcmd_t next_fl_cmd;
  logic [23:0] next_fl_addr, next_fl_wdata;
  logic [23:0] tbl_addr;                // 24-bit table target
  logic [23:0] wlat;                    // latch picked by table write
  logic [1:0]  last_word;               // final ram word of a pair
  logic        op_ok;                   // operation code implemented

  // map a program word onto the 16-bit table read result
  function automatic logic [15:0] map_read(input logic [23:0] w,
    input logic hi, input logic by, input logic bs);
    logic [15:0] r;
    r = 16'h0000;
    if (!hi && !by) begin
      r = w[15:0];
    end else if (!hi) begin
      r = {8'h00, bs ? w[15:8] : w[7:0]};
    end else if (!by) begin
      r = {8'h00, w[23:16]};
    end else begin
      r = {8'h00, bs ? 8'h00 : w[23:16]};
    end
    return r;
  endfunction

  // link handshake outputs
  // stall while busy
  assign bus.stall    = (state != ST_IDLE);
  assign bus.ack      = ack;
  assign bus.rdata    = rdata;
  assign bus.done_irq = done;
  assign ram_addr     = src;

  // next-state logic of the whole controller
  always_comb begin
    next_state = state; next_key = key; next_page = page;
    next_start = start; next_enable = enable; next_err = err;
    next_fmt = fmt; next_op = op; next_adr = adr; next_src = src;
    next_lat0 = lat0; next_lat1 = lat1; next_slot = slot;
    next_wcnt = wcnt; next_pairs = pairs; next_rd_high = rd_high;
    next_rd_byte = rd_byte; next_rd_sel = rd_sel; next_ack = 1'b0;
    next_rdata = rdata; next_done = 1'b0; next_fl_req = fl_req;
    next_fl_cmd = fl_cmd; next_fl_addr = fl_addr;
    next_fl_wdata = fl_wdata; next_ram_req = ram_req;
    tbl_addr = {page, bus.addr};
    wlat = tbl_addr[1] ? lat1 : lat0;
    last_word = fmt ? 2'd2 : 2'd3;
    op_ok = (bus.wdata[3:0] == `FSP_OP_DWORD) ||
            (bus.wdata[3:0] == `FSP_OP_ROW) ||
            (bus.wdata[3:0] == `FSP_OP_PAGE) ||
            (bus.wdata[3:0] == `FSP_OP_BULK);
    unique case (state)
      ST_IDLE: if (bus.req) begin
        next_ack = 1'b1;
        // any other write drops unlock, reads keep it
        if (bus.kind == fsp_pkg::REQ_TBL_WR ||
            bus.kind == fsp_pkg::REQ_REG_WR) next_key = KEY_NONE;
        unique case (bus.kind)
          fsp_pkg::REQ_TBL_RD: begin
            // answer waits for the array read
            next_ack = 1'b0;
            next_rd_high = bus.high;
            next_rd_byte = bus.byte_mode;
            next_rd_sel = bus.addr[0];
            next_fl_req = 1'b1;
            next_fl_cmd = fsp_pkg::FL_READ;
            next_fl_addr = {tbl_addr[23:1], 1'b0};
            next_state = ST_TRD;
          end
          fsp_pkg::REQ_TBL_WR: begin
            // low 15..0, high 23..16, word or byte
            if (bus.high && (!bus.byte_mode || !bus.addr[0]))
              wlat[23:16] = bus.wdata[7:0];
            else if (!bus.high && !bus.byte_mode)
              wlat[15:0] = bus.wdata;
            else if (!bus.high && bus.addr[0])
              wlat[15:8] = bus.wdata[7:0];
            else if (!bus.high)
              wlat[7:0] = bus.wdata[7:0];
            if (tbl_addr[1]) next_lat1 = wlat;
            else next_lat0 = wlat;
          end
          fsp_pkg::REQ_REG_RD: begin
            unique case (bus.sel)
              `FSP_REG_CTRL: next_rdata = {start, enable, err, 3'b000,
                fmt, 5'b00000, op};
              `FSP_REG_ADRL: next_rdata = adr[15:0];
              `FSP_REG_ADRU: next_rdata = {8'h00, adr[23:16]};
              `FSP_REG_SRCL: next_rdata = src[15:0];
              `FSP_REG_SRCH: next_rdata = {8'h00, src[23:16]};
              `FSP_REG_PAGE: next_rdata = {8'h00, page};
              default: next_rdata = 16'h0000;
            endcase
          end
          fsp_pkg::REQ_REG_WR: begin
            unique case (bus.sel)
              `FSP_REG_KEY: begin
                // first and second key in a row
                if (bus.wdata == `FSP_KEY_FIRST) next_key = KEY_HALF;
                else if (bus.wdata == `FSP_KEY_SECOND && key == KEY_HALF)
                  next_key = KEY_OPEN;
              end
              `FSP_REG_ADRL: next_adr[15:0] = bus.wdata;
              `FSP_REG_ADRU: next_adr[23:16] = bus.wdata[7:0];
              `FSP_REG_SRCL: next_src[15:0] = bus.wdata;
              `FSP_REG_SRCH: next_src[23:16] = bus.wdata[7:0];
              `FSP_REG_PAGE: next_page = bus.wdata[7:0];
              `FSP_REG_CTRL: begin
                next_enable = bus.wdata[`FSP_CTRL_ENABLE];
                next_err = bus.wdata[`FSP_CTRL_ERR];
                next_fmt = bus.wdata[`FSP_CTRL_FMT];
                next_op = bus.wdata[3:0];
                if (bus.wdata[`FSP_CTRL_START]) begin
                  if (key != KEY_OPEN || !bus.wdata[`FSP_CTRL_ENABLE] ||
                      !op_ok) begin
                    next_err = 1'b1;
                  end else begin
                    next_start = 1'b1;
                    next_fl_req = 1'b1;
                    unique case (bus.wdata[3:0])
                      `FSP_OP_PAGE: begin
                        next_fl_cmd = fsp_pkg::FL_ERASE_PAGE;
                        next_fl_addr = adr & ~(`FSP_PAGE_UNITS - 24'h1);
                        next_state = ST_ERASE;
                      end
                      `FSP_OP_BULK: begin
                        next_fl_cmd = fsp_pkg::FL_ERASE_ALL;
                        next_fl_addr = adr;
                        next_state = ST_ERASE;
                      end
                      `FSP_OP_ROW: begin
                        next_adr = adr & ~(`FSP_ROW_UNITS - 24'h1);
                        next_pairs = `FSP_ROW_PAIRS - 7'h1;
                        next_wcnt = 2'd0;
                        next_fl_req = 1'b0;
                        next_ram_req = 1'b1;
                        next_state = ST_FETCH;
                      end
                      default: begin
                        // double-word on a four-unit boundary
                        next_adr = adr & ~(`FSP_DWORD_UNITS - 24'h1);
                        next_fl_cmd = fsp_pkg::FL_PROG;
                        next_fl_addr = next_adr;
                        next_fl_wdata = lat0;
                        next_slot = 1'b0;
                        next_pairs = 7'h00;
                        next_state = ST_PROG;
                      end
                    endcase
                  end
                end
              end
              default: ;
            endcase
          end
        endcase
      end
      ST_TRD: if (fl_done) begin
        next_fl_req = 1'b0;
        next_rdata = map_read(fl_rdata, rd_high, rd_byte, rd_sel);
        next_ack = 1'b1;
        next_state = ST_IDLE;
      end
      ST_ERASE: if (fl_done) begin
        next_fl_req = 1'b0;
        next_start = 1'b0;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      ST_FETCH: if (ram_ack) begin
        next_src = src + 24'h2;
        unique case (wcnt)
          2'd0: next_lat0[15:0] = ram_rdata;
          2'd1: begin
            next_lat0[23:16] = ram_rdata[7:0];
            if (fmt) next_lat1[23:16] = ram_rdata[15:8];
          end
          2'd2: if (fmt) next_lat1[15:0] = ram_rdata;
            else next_lat1[15:0] = ram_rdata;
          default: next_lat1[23:16] = ram_rdata[7:0];
        endcase
        if (wcnt == last_word) begin
          next_ram_req = 1'b0;
          next_slot = 1'b0;
          next_fl_req = 1'b1;
          next_fl_cmd = fsp_pkg::FL_PROG;
          next_fl_addr = adr;
          next_fl_wdata = next_lat0;
          next_state = ST_PROG;
        end else begin
          next_wcnt = wcnt + 2'd1;
        end
      end
      default: if (fl_done) begin
        next_adr = adr + 24'h2;
        if (!slot) begin
          next_slot = 1'b1;
          next_fl_addr = adr + 24'h2;
          next_fl_wdata = lat1;
        end else if (pairs != 7'h00) begin
          next_fl_req = 1'b0;
          next_pairs = pairs - 7'h1;
          next_wcnt = 2'd0;
          next_ram_req = 1'b1;
          next_state = ST_FETCH;
        end else begin
          next_fl_req = 1'b0;
          next_start = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // state registers, all cleared by reset except the write latches, set to ffffff
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE; key <= KEY_NONE; page <= 8'h00;
      {start, enable, err} <= 3'b000; fmt <= 1'b0; op <= 4'h0;
      adr <= 24'h000000; src <= 24'h000000;
      lat0 <= 24'hffffff; lat1 <= 24'hffffff;
      slot <= 1'b0; wcnt <= 2'd0; pairs <= 7'h00;
      {rd_high, rd_byte, rd_sel} <= 3'b000;
      ack <= 1'b0; rdata <= 16'h0000; done <= 1'b0;
      fl_req <= 1'b0; fl_cmd <= fsp_pkg::FL_READ;
      fl_addr <= 24'h000000; fl_wdata <= 24'h000000; ram_req <= 1'b0;
    end else begin
      state <= next_state; key <= next_key; page <= next_page;
      start <= next_start; enable <= next_enable; err <= next_err;
      fmt <= next_fmt; op <= next_op; adr <= next_adr; src <= next_src;
      lat0 <= next_lat0; lat1 <= next_lat1; slot <= next_slot;
      wcnt <= next_wcnt; pairs <= next_pairs; rd_high <= next_rd_high;
      rd_byte <= next_rd_byte; rd_sel <= next_rd_sel; ack <= next_ack;
      rdata <= next_rdata; done <= next_done; fl_req <= next_fl_req;
      fl_cmd <= next_fl_cmd; fl_addr <= next_fl_addr;
      fl_wdata <= next_fl_wdata; ram_req <= next_ram_req;
    end
  end
endmodule
`default_nettype wire

/* fsp_core.sv */
// Purpose: processor-core end of the flash self-program link
// Assumes: user issues one command at a time through cmd_valid/ready
// Notes:   start command runs unlock, start, idle gap and polling
`timescale 1ns/1ns
`default_nettype none
`include "fsp_regs.svh"
module fsp_core (
  // system
  input  wire logic               clk,
  input  wire logic               reset,
  // user command side
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire fsp_pkg::fsp_ucmd_t cmd_kind,
  input  wire logic               cmd_high,
  input  wire logic               cmd_byte,
  input  wire logic [2:0]         cmd_sel,
  input  wire logic [15:0]        cmd_addr,
  input  wire logic [15:0]        cmd_wdata,
  output logic                    rsp_valid,
  output logic [15:0]             rsp_data,
  // core link
  fsp_if.core                     bus
);
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT, H_NOP} fsp_hstate_t;

  fsp_hstate_t        state, next_state;   // link sequencer
  logic               starting, next_starting; // start command running
  logic [1:0]         seq, next_seq;       // step of start command
  logic               nop, next_nop;       // idle gap counter
  logic [15:0]        ctrl, next_ctrl;     // control value to start
  logic               req, next_req;
  fsp_pkg::fsp_req_t  kind, next_kind;
  logic               high, next_high, bmode, next_bmode;
  logic [2:0]         sel, next_sel;
  logic [15:0]        addr, next_addr, wdata, next_wdata;
  logic               rsp_v, next_rsp_v;
  logic [15:0]        rsp_d, next_rsp_d;

  assign cmd_ready = (state == H_IDLE);
  assign rsp_valid = rsp_v;
  assign rsp_data = rsp_d;
  assign bus.req = req;
  assign bus.kind = kind;
  assign bus.high = high;
  assign bus.byte_mode = bmode;
  assign bus.sel = sel;
  assign bus.addr = addr;
  assign bus.wdata = wdata;

  // sequencing of link requests
  always_comb begin
    next_state = state; next_starting = starting; next_seq = seq;
    next_nop = nop; next_ctrl = ctrl; next_req = req; next_kind = kind;
    next_high = high; next_bmode = bmode; next_sel = sel;
    next_addr = addr; next_wdata = wdata; next_rsp_v = 1'b0;
    next_rsp_d = rsp_d;
    unique case (state)
      H_IDLE: if (cmd_valid) begin
        next_req = 1'b1;
        next_state = H_SEND;
        next_high = cmd_high; next_bmode = cmd_byte; next_sel = cmd_sel;
        next_addr = cmd_addr; next_wdata = cmd_wdata;
        next_starting = (cmd_kind == fsp_pkg::UC_START);
        unique case (cmd_kind)
          fsp_pkg::UC_TBL_RD: next_kind = fsp_pkg::REQ_TBL_RD;
          fsp_pkg::UC_TBL_WR: next_kind = fsp_pkg::REQ_TBL_WR;
          fsp_pkg::UC_REG_RD: next_kind = fsp_pkg::REQ_REG_RD;
          fsp_pkg::UC_REG_WR: next_kind = fsp_pkg::REQ_REG_WR;
          default: begin
            next_ctrl = cmd_wdata;
            next_kind = fsp_pkg::REQ_REG_WR;
            next_sel = `FSP_REG_KEY;
            next_wdata = `FSP_KEY_FIRST;
            next_seq = 2'd0;
          end
        endcase
      end
      // request taken on the first edge without stall
      H_SEND: if (!bus.stall) begin
        next_req = 1'b0;
        next_state = H_WAIT;
      end
      H_WAIT: if (bus.ack) begin
        next_state = H_SEND;
        next_req = 1'b1;
        if (!starting) begin
          next_req = 1'b0;
          next_rsp_v = 1'b1;
          next_rsp_d = bus.rdata;
          next_state = H_IDLE;
        end else if (seq == 2'd0) begin
          next_wdata = `FSP_KEY_SECOND;
          next_seq = 2'd1;
        end else if (seq == 2'd1) begin
          next_sel = `FSP_REG_CTRL;
          next_wdata = ctrl | 16'h8000;
          next_seq = 2'd2;
        end else if (seq == 2'd2) begin
          next_req = 1'b0;
          next_nop = 1'b0;
          next_seq = 2'd3;
          next_state = H_NOP;
        end else if (bus.rdata[`FSP_CTRL_START]) begin
          next_kind = fsp_pkg::REQ_REG_RD;
        end else begin
          next_req = 1'b0;
          next_rsp_v = 1'b1;
          next_rsp_d = bus.rdata;
          next_state = H_IDLE;
        end
      end
      default: begin
        next_nop = 1'b1;
        if (nop) begin
          next_req = 1'b1;
          next_kind = fsp_pkg::REQ_REG_RD;
          next_sel = `FSP_REG_CTRL;
          next_state = H_SEND;
        end
      end
    endcase
  end

  // registers of the core end
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= H_IDLE; starting <= 1'b0; seq <= 2'd0; nop <= 1'b0;
      ctrl <= `FSP_CTRL_RESET; req <= 1'b0;
      kind <= fsp_pkg::REQ_REG_RD; high <= 1'b0; bmode <= 1'b0;
      sel <= 3'h0; addr <= 16'h0000; wdata <= 16'h0000;
      rsp_v <= 1'b0; rsp_d <= 16'h0000;
    end else begin
      state <= next_state; starting <= next_starting; seq <= next_seq;
      nop <= next_nop; ctrl <= next_ctrl; req <= next_req;
      kind <= next_kind; high <= next_high; bmode <= next_bmode;
      sel <= next_sel; addr <= next_addr; wdata <= next_wdata;
      rsp_v <= next_rsp_v; rsp_d <= next_rsp_d;
    end
  end
endmodule
`default_nettype wire

/* fsp_chk.sv */
// Purpose: link checks between core end and controller end
// Assumes: one clock, synchronous high reset
// Notes:   watches the shared link signals only
`timescale 1ns/1ns
`default_nettype none
module fsp_chk (
  // system
  input wire logic              clk,
  input wire logic              reset,
  // link
  input wire logic              req,
  input wire fsp_pkg::fsp_req_t kind,
  input wire logic              stall,
  input wire logic              ack,
  input wire logic              done_irq,
  input wire logic [15:0]       rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a request accepted by the controller
  sequence s_take;
    req && !stall;
  endsequence
  property p_wr_ack;
    s_take ##0 kind == fsp_pkg::REQ_REG_WR |=> ack;
  endproperty
  property p_rd_stall;
    s_take ##0 kind == fsp_pkg::REQ_TBL_RD |=> stall && !ack;
  endproperty
  property p_ack_one; ack |=> !ack; endproperty
  property p_irq_one; done_irq |=> !done_irq; endproperty
  property p_irq_free; done_irq |-> !stall; endproperty
  property p_stall_end; $fell(stall) |-> ack || done_irq; endproperty
  property p_stall_max; $rose(stall) |-> ##[1:1000] !stall; endproperty
  // rdata moves only in the cycle that ack marks it
  property p_rd_hold; !ack |-> $stable(rdata); endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("no write ack");
  a_rd_stall: assert property (p_rd_stall) else $error("no stall");
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  a_irq_one: assert property (p_irq_one) else $error("long irq");
  a_irq_free: assert property (p_irq_free) else $error("irq busy");
  a_stall_end: assert property (p_stall_end) else $error("bad end");
  a_stall_max: assert property (p_stall_max) else $error("hang");
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench of both link ends
// Assumes: flash and ram answered at once by the bench
// Notes:   fixed flash word 7eb4c2, ram word equals its address
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, reset = 1, cv = 0, ch = 0, cb = 0, rdy, rv, fr, fd = 0;
  logic rr;
  fsp_pkg::fsp_ucmd_t ck = fsp_pkg::UC_REG_RD;
  fsp_pkg::fsp_fcmd_t fc;
  logic [2:0]  cs = 0;
  logic [15:0] ca = 0, cw = 0, rd;
  logic [23:0] fa, fw, ra, pa, pw, xa, ta, la, lw;
  int errors = 0, compares = 0, np = 0, ne = 0, nd = 0;
  logic [15:0] tx [6] = '{16'hb4c2, 16'h00c2, 16'h00b4, 16'h007e,
                          16'h007e, 16'h0000};
  fsp_if u_fsp_if ();
  fsp_core u_fsp_core (.clk(clk), .reset(reset), .cmd_valid(cv),
    .cmd_ready(rdy), .cmd_kind(ck), .cmd_high(ch), .cmd_byte(cb),
    .cmd_sel(cs), .cmd_addr(ca), .cmd_wdata(cw), .rsp_valid(rv),
    .rsp_data(rd), .bus(u_fsp_if));
  fsp_ctrl u_fsp_ctrl (.clk(clk), .reset(reset), .bus(u_fsp_if),
    .fl_req(fr), .fl_cmd(fc), .fl_addr(fa), .fl_wdata(fw),
    .fl_rdata(24'h7eb4c2), .fl_done(fd), .ram_req(rr), .ram_addr(ra),
    .ram_rdata(ra[15:0]), .ram_ack(rr));
  fsp_chk u_fsp_chk (.clk(clk), .reset(reset), .req(u_fsp_if.req),
    .kind(u_fsp_if.kind), .stall(u_fsp_if.stall), .ack(u_fsp_if.ack),
    .done_irq(u_fsp_if.done_irq), .rdata(u_fsp_if.rdata));
  always #20 clk = ~clk;
  // flash array: one done pulse per request, log what it was asked
  always @(posedge clk) begin
    fd <= #1 fr && !fd;
    // completion pulses are counted as the core link carries them
    if (u_fsp_if.done_irq) nd++;
    if (fr && fd) begin
      if (fc == fsp_pkg::FL_PROG && np == 0) {pa, pw} = {fa, fw};
      if (fc == fsp_pkg::FL_PROG) begin
        {la, lw} = {fa, fw};
        np++;
      end
      if (fc == fsp_pkg::FL_ERASE_PAGE) begin xa = fa; ne++; end
      if (fc == fsp_pkg::FL_READ) ta = fa;
    end
  end
  task automatic chk(string n, logic [23:0] s, logic [23:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  // one user command, waits for its response under a bound
  task automatic cmd(fsp_pkg::fsp_ucmd_t k, logic h, logic b,
                     logic [2:0] s, logic [15:0] a, logic [15:0] w);
    int n;
    n = 0;
    while (rdy !== 1'b1) @(posedge clk) #1;
    cv = 1'b1;
    ck = k;
    {ch, cb, cs, ca, cw} = {h, b, s, a, w};
    @(posedge clk) #1 cv = 0;
    while (rv !== 1'b1 && n < 5000) begin @(posedge clk) #1; n++; end
    // a command that never answers ends the run as a failure
    if (rv !== 1'b1) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // tests take under 2000 cycles, the bound allows 10000
  initial begin #400000; errors++; give_verdict(); end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 0;
    cmd(fsp_pkg::UC_REG_WR, 1'b0, 1'b0, 3'h6, 16'h0000, 16'h00ab);
    for (int i = 0; i < 6; i++) begin
      cmd(fsp_pkg::UC_TBL_RD, i > 2, i % 3 != 0, 3'h0,
          16'h1234 + (i % 3 == 2), 16'h0000);
      chk("table read", rd, tx[i]);
    end
    chk("table addr", ta, 24'hab1234);
    $display("test tables done");
    cmd(fsp_pkg::UC_REG_WR, 1'b0, 1'b0, 3'h4, 16'h0000, 16'h0100);
    cmd(fsp_pkg::UC_REG_WR, 1'b0, 1'b0, 3'h5, 16'h0000, 16'h0000);
    cmd(fsp_pkg::UC_REG_WR, 1'b0, 1'b0, 3'h2, 16'h0000, 16'h1234);
    cmd(fsp_pkg::UC_REG_WR, 1'b0, 1'b0, 3'h3, 16'h0000, 16'h0001);
    // page erased before anything in it is written
    cmd(fsp_pkg::UC_START, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h4003);
    chk("erase addr", xa, 24'h011000);
    cmd(fsp_pkg::UC_START, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h4002);
    chk("start clear", rd[15], 1'b0);
    chk("row first addr", pa, 24'h011200);
    chk("row first word", pw, 24'h020100);
    chk("row count", np, 128);
    // latch 1: low word, high byte, phantom byte ignored
    cmd(fsp_pkg::UC_TBL_WR, 1'b0, 1'b0, 3'h0, 16'h0002, 16'h5678);
    cmd(fsp_pkg::UC_TBL_WR, 1'b1, 1'b1, 3'h0, 16'h0002, 16'h0009);
    cmd(fsp_pkg::UC_TBL_WR, 1'b1, 1'b1, 3'h0, 16'h0003, 16'h00ff);
    cmd(fsp_pkg::UC_START, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h4001);
    chk("pair last addr", la, 24'h011302);
    chk("pair last word", lw, 24'h095678);
    chk("pair count", np, 130);
    // whole array erased before the row is written again
    cmd(fsp_pkg::UC_START, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h400e);
    cmd(fsp_pkg::UC_START, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h4202);
    chk("packed last addr", la, 24'h0113fe);
    chk("packed last word", lw, 24'h04047e);
    chk("packed count", np, 258);
    cmd(fsp_pkg::UC_REG_RD, 1'b0, 1'b0, 3'h2, 16'h0000, 16'h0000);
    chk("target low", rd, 16'h1400);
    chk("done pulses", nd, 5);
    $display("test program done");
    cmd(fsp_pkg::UC_REG_WR, 1'b0, 1'b0, 3'h0, 16'h0000, 16'hc003);
    cmd(fsp_pkg::UC_START, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h4000);
    cmd(fsp_pkg::UC_START, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0003);
    cmd(fsp_pkg::UC_REG_RD, 1'b0, 1'b0, 3'h0, 16'h0000, 16'h0000);
    chk("refused start", {rd[15], rd[13]}, 2'b01);
    chk("erase count", ne, 1);
    chk("refused pulses", nd, 5);
    chk("refused count", np, 258);
    $display("test refusal done");
    give_verdict();
  end
endmodule
`default_nettype wire
